// File: owi_command_regs_checksum.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - checksum shifts each word msb first, xor 0x107 when bit 8 sets
// R2 - checksum remainder starts at 0xFF
// R3 - checksum covers words 0..15 in order, last low byte zero when generating
// R4 - rerun with stored checksum in last low byte gives zero when valid
// R5 - master writes key 9BA4h to 94h within entry window after reset
// R6 - bit 15 read-only, shows diagnostic condition regardless of override
// R7 - bit 14 read/write override forcing diagnostic mode off, reset 0
// R8 - bit 12 read-only low supply flag
// R9 - bit 11 read/write pump clock enable, reset 0, set after write enable
// R10 - bit 8 sticky corrected-error flag, evaluated each readout
// R11 - bit 7 sticky uncorrectable-error flag, evaluated each readout
// R12 - bit 6 sticky magnet flag, diagnostic only when detection enabled
// R13 - bit 4 read-only flag for failed start-up checksum check
// R14 - write-gate bit 11 is nv write enable, 0605h off, 0E05h on
// R15 - reserved bits of both registers carry no function
// R16 - command byte: region 7..5, address 4..1, bit 0 write/read
// R17 - command mode is held until power-on reset
// R18 - master waits pump settling and programming times (model waits PUMP_SETTLE cycles only, no programming wait)
// R19 - reserved and write-only bits read zero, read-only writes ignored
module owi_command_regs_checksum
  import owi_cmd_pkg::*;
#(
  parameter int ENTRY_WINDOW_CYCLES = ENTRY_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic [15:0] wr_data,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  input  wire logic        diag_condition,
  input  wire logic        supply_low,
  input  wire logic        nv_readout,
  input  wire logic        nv_corrected,
  input  wire logic        nv_fatal,
  input  wire logic        magnet_absent,
  input  wire logic        magnet_detect_en,
  input  wire logic        boot_word_valid,
  input  wire logic [15:0] boot_word,
  output logic             command_mode,
  output logic             diagnostic_mode,
  output logic             pump_clock_enable,
  output logic             nv_write_enable,
  output logic             checksum_bad,
  output logic [7:0]       generated_checksum
);
  // ----------------------------------------
  // checksum engine
  // ----------------------------------------
  crc_link_if lnk ();
  crc8_engine crc8_engine_i (.clk(clk), .rst(rst), .lnk(lnk));

  typedef enum logic [1:0] {BOOT_SEED, BOOT_RUN, BOOT_DONE} boot_e;

  boot_e       boot_state;
  boot_e       next_boot_state;
  logic [3:0]  boot_idx;
  logic [3:0]  next_boot_idx;
  logic        next_checksum_bad;
  logic [7:0]  next_generated;

  // ----------------------------------------
  // start-up verification
  // ----------------------------------------
  always_comb begin
    next_boot_state   = boot_state;
    next_boot_idx     = boot_idx;
    next_checksum_bad = checksum_bad;
    next_generated    = generated_checksum;
    lnk.start         = 1'b0;
    lnk.word_valid    = 1'b0;
    lnk.word          = boot_word;
    lnk.last          = (boot_idx == LAST_WORD); // R3
    case (boot_state)
      BOOT_SEED: begin
        lnk.start       = 1'b1;
        next_boot_state = BOOT_RUN;
      end
      BOOT_RUN: begin
        // a word arriving with the done pulse would be a seventeenth
        if (boot_word_valid && !lnk.done) begin
          lnk.word_valid = 1'b1;
          next_boot_idx  = boot_idx + 4'h1;
        end
        if (lnk.done) begin
          next_checksum_bad = (lnk.check_rem != 8'h00); // R4 R13
          next_generated    = lnk.gen_crc;
          next_boot_state   = BOOT_DONE;
        end
      end
      default: begin
        next_boot_state = BOOT_DONE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_state         <= BOOT_SEED;
      boot_idx           <= 4'h0;
      checksum_bad       <= 1'b0;
      generated_checksum <= 8'h00;
    end else begin
      boot_state         <= next_boot_state;
      boot_idx           <= next_boot_idx;
      checksum_bad       <= next_checksum_bad;
      generated_checksum <= next_generated;
    end
  end

  // ----------------------------------------
  // command decode and registers
  // ----------------------------------------
  logic [31:0] window_cnt;
  logic [31:0] next_window_cnt;
  logic        window_open;
  logic        next_command_mode;
  logic        override;
  logic        next_override;
  logic        next_pump;
  logic        next_nv_we;
  logic        corrected_flag;
  logic        next_corrected;
  logic        fatal_flag;
  logic        next_fatal;
  logic        magnet_flag;
  logic        next_magnet;
  logic        diag_active;
  logic        next_diag_mode;
  logic        next_rd_valid;
  logic [15:0] next_rd_data;
  logic        is_reg;
  logic        is_read;
  logic [15:0] status_word;

  assign window_open = (window_cnt < ENTRY_WINDOW_CYCLES);
  assign is_reg      = (cmd_byte[REGION_HI:REGION_LO] == REGION_REG); // R16
  assign is_read     = cmd_byte[DIR_BIT]; // R16
  // magnet flag counts only with detection enabled
  assign diag_active = diag_condition | (magnet_flag & magnet_detect_en); // R12

  // status word, reserved bits zero
  always_comb begin
    status_word                  = 16'h0000; // R15 R19
    status_word[DIAG_ACTIVE_BIT] = diag_active; // R6
    status_word[OVERRIDE_BIT]    = override; // R7
    status_word[SUPPLY_LOW_BIT]  = supply_low; // R8
    status_word[PUMP_CLK_BIT]    = pump_clock_enable; // R9
    status_word[CORRECTED_BIT]   = corrected_flag; // R10
    status_word[FATAL_BIT]       = fatal_flag; // R11
    status_word[MAGNET_BIT]      = magnet_flag; // R12
    status_word[CRC_BAD_BIT]     = checksum_bad; // R13
  end

  always_comb begin
    next_window_cnt   = window_open ? window_cnt + 32'h1 : window_cnt;
    next_command_mode = command_mode; // R17
    next_override     = override;
    next_pump         = pump_clock_enable;
    next_nv_we        = nv_write_enable;
    next_rd_valid     = 1'b0;
    next_rd_data      = rd_data;
    // sticky flags only set, never cleared by a command
    next_corrected    = corrected_flag | (nv_readout & nv_corrected); // R10
    next_fatal        = fatal_flag | (nv_readout & nv_fatal); // R11
    next_magnet       = magnet_flag | magnet_absent; // R12
    next_diag_mode    = diag_active & ~override; // R6 R7
    if (cmd_valid && !command_mode) begin
      if (cmd_byte == CMD_KEY_WR && wr_data == ENTRY_KEY && window_open) begin
        next_command_mode = 1'b1; // R5
      end
    end else if (cmd_valid && is_reg) begin
      if (is_read) begin
        next_rd_valid = 1'b1;
        if (cmd_byte == CMD_STATUS_RD) begin
          next_rd_data = status_word; // R6
        end else begin
          next_rd_data = 16'h0000; // R19
        end
      end else if (cmd_byte == CMD_STATUS_WR) begin
        next_override = wr_data[OVERRIDE_BIT]; // R7
        next_pump     = wr_data[PUMP_CLK_BIT]; // R9 R19
      end else if (cmd_byte == CMD_GATE_WR) begin
        next_nv_we = wr_data[NV_WE_BIT]; // R14 R15
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      window_cnt        <= 32'h0;
      command_mode      <= 1'b0;
      override          <= 1'b0;
      pump_clock_enable <= 1'b0;
      nv_write_enable   <= GATE_RESET[NV_WE_BIT];
      corrected_flag    <= 1'b0;
      fatal_flag        <= 1'b0;
      magnet_flag       <= 1'b0;
      diagnostic_mode   <= 1'b0;
      rd_valid          <= 1'b0;
      rd_data           <= 16'h0000;
    end else begin
      window_cnt        <= next_window_cnt;
      command_mode      <= next_command_mode;
      override          <= next_override;
      pump_clock_enable <= next_pump;
      nv_write_enable   <= next_nv_we;
      corrected_flag    <= next_corrected;
      fatal_flag        <= next_fatal;
      magnet_flag       <= next_magnet;
      diagnostic_mode   <= next_diag_mode;
      rd_valid          <= next_rd_valid;
      rd_data           <= next_rd_data;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_key_entry: assert property ( // R5
    cmd_valid && !command_mode && cmd_byte == CMD_KEY_WR && wr_data == ENTRY_KEY && window_open
    |=> command_mode) else $error("key not accepted");
  a_no_entry_late: assert property ( // R5
    !command_mode && !window_open |=> !command_mode) else $error("entry after window");
  a_mode_held: assert property (command_mode |=> command_mode) // R17
    else $error("command mode left");
  a_override_write: assert property ( // R7
    command_mode && cmd_valid && cmd_byte == CMD_STATUS_WR
    |=> override == $past(wr_data[OVERRIDE_BIT])) else $error("override not written");
  a_pump_write: assert property ( // R9
    command_mode && cmd_valid && cmd_byte == CMD_STATUS_WR
    |=> pump_clock_enable == $past(wr_data[PUMP_CLK_BIT])) else $error("pump enable not written");
  a_gate_write: assert property ( // R14
    command_mode && cmd_valid && cmd_byte == CMD_GATE_WR
    |=> nv_write_enable == $past(wr_data[NV_WE_BIT])) else $error("write enable not written");
  a_error_sticky: assert property ( // R10 R11
    corrected_flag && fatal_flag |=> corrected_flag && fatal_flag) else $error("error flag cleared");
  a_fatal_set: assert property ( // R11
    nv_readout && nv_fatal |=> fatal_flag) else $error("fatal flag not set");
  a_magnet_sticky: assert property ( // R12
    magnet_absent |=> magnet_flag [*2]) else $error("magnet flag not held");
  a_status_read: assert property ( // R6 R15
    command_mode && cmd_valid && cmd_byte == CMD_STATUS_RD
    |=> rd_valid && rd_data[DIAG_ACTIVE_BIT] == $past(diag_active) && rd_data[13] == 1'b0
        && rd_data[3:0] == 4'h0) else $error("status read wrong");
  a_gate_read_zero: assert property ( // R19
    command_mode && cmd_valid && cmd_byte == CMD_GATE_RD |=> rd_valid && rd_data == 16'h0000)
    else $error("write-only read not zero");
  a_diag_override: assert property ( // R7
    override |=> !diagnostic_mode) else $error("override ignored");

  c_enter_mode: cover property (!command_mode ##1 command_mode);
  c_status_read: cover property (rd_valid && rd_data[CRC_BAD_BIT]);
  c_boot_done: cover property (boot_state == BOOT_RUN ##1 boot_state == BOOT_DONE);
  c_pump_on: cover property (nv_write_enable && pump_clock_enable);
endmodule : owi_command_regs_checksum

// File: owi_cmd_pkg.sv
package owi_cmd_pkg;
  // ----------------------------------------
  // command byte layout
  // ----------------------------------------
  localparam int          REGION_HI      = 7;
  localparam int          REGION_LO      = 5;
  localparam logic [2:0]  REGION_NV      = 3'h0;
  localparam logic [2:0]  REGION_REG     = 3'h4;
  localparam int          DIR_BIT        = 0;
  localparam logic [7:0]  CMD_STATUS_WR  = 8'h82;
  localparam logic [7:0]  CMD_STATUS_RD  = 8'h83;
  localparam logic [7:0]  CMD_KEY_WR     = 8'h94;
  localparam logic [7:0]  CMD_GATE_WR    = 8'h96;
  localparam logic [7:0]  CMD_GATE_RD    = 8'h97;
  localparam logic [15:0] ENTRY_KEY      = 16'h9BA4;
  // ----------------------------------------
  // status/control and write-gate fields
  // ----------------------------------------
  localparam int          DIAG_ACTIVE_BIT = 15;
  localparam int          OVERRIDE_BIT    = 14;
  localparam int          SUPPLY_LOW_BIT  = 12;
  localparam int          PUMP_CLK_BIT    = 11;
  localparam int          CORRECTED_BIT   = 8;
  localparam int          FATAL_BIT       = 7;
  localparam int          MAGNET_BIT      = 6;
  localparam int          CRC_BAD_BIT     = 4;
  localparam int          NV_WE_BIT       = 11;
  localparam logic [15:0] GATE_RESET      = 16'h0605;
  localparam logic [15:0] GATE_ENABLED    = 16'h0E05;
  // ----------------------------------------
  // checksum
  // ----------------------------------------
  localparam logic [8:0]  CRC_POLY        = 9'h107;
  localparam logic [8:0]  CRC_SEED        = 9'h0FF;
  localparam int          NV_WORDS        = 16;
  localparam logic [3:0]  LAST_WORD       = 4'hF;
  // ----------------------------------------
  // entry window after reset
  // ----------------------------------------
  localparam int          CLK_PERIOD_NS   = 4;
  localparam int          ENTRY_WINDOW_NS = 20000000;
  localparam int          ENTRY_CYCLES    = ENTRY_WINDOW_NS / CLK_PERIOD_NS;
endpackage : owi_cmd_pkg

// File: crc_link_if.sv
`timescale 1ns/1ps
interface crc_link_if;
  logic        start;      // reload seed
  logic        word_valid; // one word this cycle
  logic [15:0] word;
  logic        last;       // word is index 15
  logic [7:0]  check_rem;  // remainder over words as stored
  logic [7:0]  gen_crc;    // remainder with last low byte zeroed
  logic        done;       // pulse after last word
  modport ctrl (output start, word_valid, word, last, input check_rem, gen_crc, done);
  modport eng  (input start, word_valid, word, last, output check_rem, gen_crc, done);
endinterface : crc_link_if

// File: crc8_engine.sv
`timescale 1ns/1ps
module crc8_engine
  import owi_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  crc_link_if.eng  lnk
);
  // ----------------------------------------
  // word step, msb first
  // ----------------------------------------
  function automatic logic [8:0] crc_word(input logic [8:0] c_in, input logic [15:0] d);
    logic [8:0] c;
    c = c_in;
    for (int i = 15; i >= 0; i--) begin
      c = {c[7:0], d[i]}; // R1
      if (c[8]) begin
        c = c ^ CRC_POLY; // R1
      end
    end
    return c;
  endfunction : crc_word

  logic [8:0] chk;
  logic [8:0] gen;
  logic       done_q;
  logic [8:0] next_chk;
  logic [8:0] next_gen;
  logic       next_done;

  // next remainders
  always_comb begin
    next_chk  = chk;
    next_gen  = gen;
    next_done = 1'b0;
    if (lnk.start) begin
      next_chk = CRC_SEED; // R2
      next_gen = CRC_SEED; // R2
    end else if (lnk.word_valid) begin
      next_chk  = crc_word(chk, lnk.word); // R4
      next_gen  = crc_word(gen, lnk.last ? {lnk.word[15:8], 8'h00} : lnk.word); // R3
      next_done = lnk.last;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chk    <= CRC_SEED;
      gen    <= CRC_SEED;
      done_q <= 1'b0;
    end else begin
      chk    <= next_chk;
      gen    <= next_gen;
      done_q <= next_done;
    end
  end

  assign lnk.check_rem = chk[7:0];
  assign lnk.gen_crc   = gen[7:0];
  assign lnk.done      = done_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_seed_value: assert property (@(posedge clk) disable iff (rst) lnk.start |=> chk == CRC_SEED) // R2
    else $error("seed not loaded");
  a_msb_clear: assert property (@(posedge clk) disable iff (rst) 1'b1 |-> !chk[8] && !gen[8]) // R1
    else $error("remainder bit 8 left set");
  a_gen_ignores: assert property (@(posedge clk) disable iff (rst)
    lnk.word_valid && lnk.last && !lnk.start |=> gen == crc_word($past(gen), {$past(lnk.word[15:8]), 8'h00})) // R3
    else $error("generation used low byte");
endmodule : crc8_engine

// File: owi_master_model.sv
`timescale 1ns/1ps
module owi_master_model #(
  parameter int PUMP_SETTLE = 8  // pump settling wait in cycles, value arbitrary
)(
  input  wire logic        clk,
  output logic             cmd_valid,
  output logic [7:0]       cmd_byte,
  output logic [15:0]      wr_data,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  import owi_cmd_pkg::*;
  // idle lines at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
    wr_data   = 16'h0000;
  end
  // one command, held over its taking edge, then released
  task automatic issue(input logic [7:0] cmd, input logic [15:0] data);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_byte  = cmd;
    wr_data   = data;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_byte  = ~cmd_byte;  // released lines lose old value
    wr_data   = ~wr_data;
  endtask : issue
  // read command, answer taken while rd_valid stands after the taking edge
  task automatic fetch(input logic [7:0] cmd, output logic got, output logic [15:0] data);
    issue(cmd, 16'h0000);
    got  = rd_valid;
    data = rd_data;
  endtask : fetch
  // entry key write
  task automatic enter();
    issue(CMD_KEY_WR, ENTRY_KEY);
  endtask : enter
  // write enable first, then pump clock, then settle
  task automatic nv_arm();
    issue(CMD_GATE_WR, GATE_ENABLED);
    issue(CMD_STATUS_WR, 16'h0800);
    repeat (PUMP_SETTLE) @(negedge clk);
  endtask : nv_arm
endmodule : owi_master_model

// File: owi_command_regs_checksum_test.sv
`timescale 1ns/1ps
module owi_command_regs_checksum_test;
  import owi_cmd_pkg::*;
  localparam int WIN = 64;
  logic        clk = 1'b0, rst = 1'b1, cmd_valid, rd_valid, got;
  logic [7:0]  cmd_byte, generated_checksum;
  logic [15:0] wr_data, rd_data, rdv, boot_word = 16'h0000;
  logic        diag_condition = 1'b0, supply_low = 1'b0, nv_readout = 1'b0, nv_corrected = 1'b0;
  logic        nv_fatal = 1'b0, magnet_absent = 1'b0, magnet_detect_en = 1'b0, boot_word_valid = 1'b0;
  logic        command_mode, diagnostic_mode, pump_clock_enable, nv_write_enable, checksum_bad;
  int          fails = 0, cmp_count = 0;

  always #2 clk = ~clk;

  owi_command_regs_checksum #(.ENTRY_WINDOW_CYCLES(WIN)) owi_command_regs_checksum_i (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .diag_condition(diag_condition), .supply_low(supply_low),
    .nv_readout(nv_readout), .nv_corrected(nv_corrected), .nv_fatal(nv_fatal),
    .magnet_absent(magnet_absent), .magnet_detect_en(magnet_detect_en),
    .boot_word_valid(boot_word_valid), .boot_word(boot_word), .command_mode(command_mode),
    .diagnostic_mode(diagnostic_mode), .pump_clock_enable(pump_clock_enable),
    .nv_write_enable(nv_write_enable), .checksum_bad(checksum_bad),
    .generated_checksum(generated_checksum));

  owi_master_model owi_master_model_i (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data));

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string msg);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, g, e);
    end
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic e, input string msg);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, msg, g, e);
    end
  endtask : chk_bit
  task automatic wrap_up();
    $display("counts: compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic do_reset();
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
  endtask : do_reset
  // fifteen start-up words 1111h..FFFFh then the given last word
  task automatic boot(input logic [15:0] last);
    for (int i = 0; i < 16; i++) begin
      boot_word_valid = 1'b1;
      boot_word       = (i == 15) ? last : 16'h1111 * 16'(i + 1);
      @(negedge clk);
    end
    boot_word_valid = 1'b0;
    boot_word       = ~boot_word;
    repeat (2) @(negedge clk);
  endtask : boot

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_boot_good();
    do_reset();
    boot(16'h426F);
    chk_word({8'h00, generated_checksum}, 16'h006F, "generated");
    chk_bit(checksum_bad, 1'b0, "check ok");
    $display("test boot_good done");
  endtask : t_boot_good
  task automatic t_entry();
    owi_master_model_i.fetch(CMD_STATUS_RD, got, rdv);
    chk_bit(got, 1'b0, "read before entry");
    owi_master_model_i.issue(CMD_KEY_WR, 16'h9BA5);
    chk_bit(command_mode, 1'b0, "wrong key");
    owi_master_model_i.enter();
    chk_bit(command_mode, 1'b1, "entered");
    $display("test entry done");
  endtask : t_entry
  task automatic t_regs();
    owi_master_model_i.nv_arm();
    chk_bit(nv_write_enable, 1'b1, "write enable");
    chk_bit(pump_clock_enable, 1'b1, "pump");
    owi_master_model_i.fetch(CMD_GATE_RD, got, rdv);
    chk_bit(got, 1'b1, "read answered");
    chk_word(rdv, 16'h0000, "gate reads zero");
    owi_master_model_i.issue(CMD_STATUS_WR, 16'hFFFF);
    owi_master_model_i.fetch(CMD_STATUS_RD, got, rdv);
    chk_word(rdv, 16'h4800, "status rw");
    owi_master_model_i.issue(CMD_GATE_WR, 16'hF7FF);
    chk_bit(nv_write_enable, 1'b0, "gate reserved");
    owi_master_model_i.issue(CMD_GATE_WR, 16'h0800);
    chk_bit(nv_write_enable, 1'b1, "gate bit only");
    owi_master_model_i.issue(CMD_GATE_WR, GATE_RESET);
    chk_bit(nv_write_enable, 1'b0, "gate off");
    $display("test regs done");
  endtask : t_regs
  task automatic t_flags();
    diag_condition = 1'b1;
    supply_low     = 1'b1;
    nv_readout     = 1'b1;
    nv_corrected   = 1'b1;
    nv_fatal       = 1'b1;
    magnet_absent  = 1'b1;
    @(negedge clk);
    nv_readout     = 1'b0;
    nv_corrected   = 1'b0;
    nv_fatal       = 1'b0;
    magnet_absent  = 1'b0;
    owi_master_model_i.fetch(CMD_STATUS_RD, got, rdv);
    chk_word(rdv, 16'hD9C0, "flags set");
    chk_bit(diagnostic_mode, 1'b0, "override");
    diag_condition = 1'b0;
    supply_low     = 1'b0;
    nv_readout     = 1'b1;
    @(negedge clk);
    nv_readout     = 1'b0;
    owi_master_model_i.fetch(CMD_STATUS_RD, got, rdv);
    chk_word(rdv, 16'h49C0, "sticky");
    magnet_detect_en = 1'b1;
    owi_master_model_i.issue(CMD_STATUS_WR, 16'h0000);
    repeat (2) @(negedge clk);
    chk_bit(diagnostic_mode, 1'b1, "magnet diag");
    owi_master_model_i.fetch(CMD_STATUS_RD, got, rdv);
    chk_word(rdv, 16'h81C0, "magnet active");
    magnet_detect_en = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(diagnostic_mode, 1'b0, "detect off");
    owi_master_model_i.enter();
    chk_bit(command_mode, 1'b1, "mode held");
    $display("test flags done");
  endtask : t_flags
  task automatic t_boot_bad();
    do_reset();
    chk_bit(command_mode, 1'b0, "reset leaves mode");
    boot(16'h4200);
    chk_bit(checksum_bad, 1'b1, "check fails");
    chk_word({8'h00, generated_checksum}, 16'h006F, "generated");
    owi_master_model_i.enter();
    owi_master_model_i.fetch(CMD_STATUS_RD, got, rdv);
    chk_word(rdv, 16'h0010, "bad flag");
    do_reset();
    repeat (WIN + 8) @(negedge clk);
    owi_master_model_i.enter();
    chk_bit(command_mode, 1'b0, "window closed");
    $display("test boot_bad done");
  endtask : t_boot_bad

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_boot_good();
    t_entry();
    t_regs();
    t_flags();
    t_boot_bad();
    wrap_up();
  end
  initial begin
    #40000;
    fails++;
    wrap_up();
  end
endmodule : owi_command_regs_checksum_test
